// >>> logic/gpt_regs.svh
// register offsets, field positions, reset values for the general purpose timer
// assumes inclusion by the timer module and its test bench only
`ifndef GPT_REGS_SVH
`define GPT_REGS_SVH
`define GPT_OFF_CONTROL 8'h10
`define GPT_OFF_CONFIG 8'h00
`define GPT_OFF_COUNT 8'h04
`define GPT_OFF_PRELOAD 8'h08
`define GPT_OFF_STATUS 8'h0c
`define GPT_OFF_MASK 8'h14
`define GPT_OFF_PRESCALE 8'h18
`define GPT_CTL_ENABLE 0
`define GPT_CFG_COUNT_UP 0
`define GPT_CFG_AUTO_RESTART 2
`define GPT_CFG_SOFT_RESET 4
`define GPT_CFG_START 5
`define GPT_ST_DONE 0
`define GPT_ST_EDGE 1
`define GPT_RST_PRELOAD 32'h0000_0000
`define GPT_RST_PRESCALE 16'h0000
`endif

// >>> logic/gpt_pkg.sv
// types shared by the general purpose timer
// assumes the register header is compiled alongside
package gpt_pkg;
    typedef logic [31:0] gpt_word_t;
    typedef enum logic [1:0] {
        GPT_IDLE = 2'b00,
        GPT_RUN = 2'b01,
        GPT_DONE = 2'b10
    } gpt_state_e;
endpackage : gpt_pkg

// >>> logic/gpt_timer.sv
// general purpose up/down timer with prescaler, preload, sticky status and mask
// assumes a synchronous single-cycle register port, one 50 MHz clock
//
// Function
// R1: start resets prescaler, loads, clears interrupts
// R2: clearing start stops prescaler and holds count
// R3: auto-restart mode never clears start itself
// R4: soft reset write-only, self-clears after one cycle
// R5: writes accepted right after soft reset
// R6: auto-restart reloads preload, edge interrupt
// R7: no auto-restart enters done, level interrupt
// R8: direction bit one counts up, zero down
// R9: up saturates at all ones, down at zero
// R10: up limit is counter width all ones
// R11: control bit0 enable gates timer clock
// R12: control bit1 reserved, reads zero
// R13: timer reset is system or soft reset
// R14: direction bit defaults zero, timer reset
// R15: one-shot completion clears start itself
// R16: start loads preload before first tick
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "gpt_regs.svh"
module gpt_timer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq
);
    localparam int unsigned CW = 32;
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction : hit

    logic soft_rst;
    logic timer_rst;
    logic enable;
    logic count_up;
    logic auto_restart;
    logic start;
    gpt_pkg::gpt_word_t count;
    gpt_pkg::gpt_word_t preload;
    logic [15:0] prescale;
    logic [15:0] div_cnt;
    logic [1:0] status;
    logic [1:0] mask;
    gpt_pkg::gpt_state_e state;
    logic next_soft_rst;
    logic next_enable;
    logic next_count_up;
    logic next_auto_restart;
    logic next_start;
    gpt_pkg::gpt_word_t next_count;
    gpt_pkg::gpt_word_t next_preload;
    logic [15:0] next_prescale;
    logic [15:0] next_div_cnt;
    logic [1:0] next_status;
    logic [1:0] next_mask;
    gpt_pkg::gpt_state_e next_state;
    logic [31:0] next_rdata;
    logic next_irq;
    logic wr_cfg;
    logic start_rise;
    logic tick;
    logic at_limit;
    logic complete;

    // soft reset lives outside the timer reset so it can release itself
    assign timer_rst = rst | soft_rst; // R13
    assign wr_cfg = reg_wr && hit(reg_addr, `GPT_OFF_CONFIG);
    assign start_rise = wr_cfg && reg_wdata[`GPT_CFG_START] && !start;
    // a divide value of n gives one tick every n+1 enabled cycles
    assign tick = enable && start && (state == gpt_pkg::GPT_RUN)
                  && (div_cnt == prescale); // R11
    assign at_limit = count_up ? (count == {CW{1'b1}}) : (count == '0); // R9 R10
    assign complete = tick && at_limit;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_soft_rst = wr_cfg && reg_wdata[`GPT_CFG_SOFT_RESET]; // R4
        next_enable = enable;
        next_count_up = count_up;
        next_auto_restart = auto_restart;
        next_start = start;
        next_preload = preload;
        next_prescale = prescale;
        next_mask = mask;
        next_status = status;
        next_count = count;
        next_div_cnt = div_cnt;
        next_state = state;
        if (reg_wr && hit(reg_addr, `GPT_OFF_CONTROL)) begin
            next_enable = reg_wdata[`GPT_CTL_ENABLE]; // R11
        end
        if (reg_wr && hit(reg_addr, `GPT_OFF_PRELOAD)) begin
            next_preload = reg_wdata;
        end
        if (reg_wr && hit(reg_addr, `GPT_OFF_PRESCALE)) begin
            next_prescale = reg_wdata[15:0];
        end
        if (reg_wr && hit(reg_addr, `GPT_OFF_MASK)) begin
            next_mask = reg_wdata[1:0];
        end
        if (reg_wr && hit(reg_addr, `GPT_OFF_STATUS)) begin
            next_status = status & ~reg_wdata[1:0];
        end
        if (reg_wr && hit(reg_addr, `GPT_OFF_COUNT)) begin
            next_count = reg_wdata;
        end
        // configuration is taken on any cycle outside timer reset, including right after soft reset
        if (wr_cfg) begin // R5
            next_count_up = reg_wdata[`GPT_CFG_COUNT_UP]; // R8
            next_auto_restart = reg_wdata[`GPT_CFG_AUTO_RESTART];
            next_start = reg_wdata[`GPT_CFG_START];
        end
        if (start_rise) begin
            next_div_cnt = '0; // R1
            next_count = preload; // R16
            next_status = '0; // R1
            next_state = gpt_pkg::GPT_RUN;
        end else if (!next_start) begin
            // a finished one-shot stays done until the next start
            if (state == gpt_pkg::GPT_RUN) begin
                next_state = gpt_pkg::GPT_IDLE; // R2
            end
        end else if (enable && state == gpt_pkg::GPT_RUN) begin
            next_div_cnt = tick ? 16'h0000 : div_cnt + 16'h0001;
            if (complete) begin
                if (auto_restart) begin
                    next_count = preload; // R6
                    next_status[`GPT_ST_EDGE] = 1'b1; // R6
                end else begin
                    next_state = gpt_pkg::GPT_DONE; // R7
                    next_status[`GPT_ST_DONE] = 1'b1; // R7
                    next_start = 1'b0; // R15
                end
            end else if (tick) begin
                next_count = count_up ? count + 32'h0000_0001 : count - 32'h0000_0001; // R8
            end
        end
        // while not running the prescaler holds still
        next_irq = |(next_status & next_mask);
        next_rdata = 32'h0000_0000;
        if (reg_rd) begin
            case (reg_addr)
                `GPT_OFF_CONTROL: next_rdata = {31'h0, enable}; // R12
                `GPT_OFF_CONFIG: next_rdata = {26'h0, start, 2'b00, auto_restart, 1'b0,
                    count_up};
                `GPT_OFF_COUNT: next_rdata = count;
                `GPT_OFF_PRELOAD: next_rdata = preload;
                `GPT_OFF_STATUS: next_rdata = {30'h0, status};
                `GPT_OFF_MASK: next_rdata = {30'h0, mask};
                `GPT_OFF_PRESCALE: next_rdata = {16'h0, prescale};
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge mclk) begin
        if (rst) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= next_soft_rst;
        end
    end

    // configuration bits
    always_ff @(posedge mclk) begin
        if (timer_rst) begin // R13 R14
            enable <= 1'b0;
            count_up <= 1'b0;
            auto_restart <= 1'b0;
            start <= 1'b0;
            preload <= `GPT_RST_PRELOAD;
            prescale <= `GPT_RST_PRESCALE;
            mask <= 2'b00;
        end else begin
            enable <= next_enable;
            count_up <= next_count_up;
            auto_restart <= next_auto_restart;
            start <= next_start;
            preload <= next_preload;
            prescale <= next_prescale;
            mask <= next_mask;
        end
    end

    // counter, prescaler and run state
    always_ff @(posedge mclk) begin
        if (timer_rst) begin // R13
            count <= 32'h0000_0000;
            div_cnt <= 16'h0000;
            state <= gpt_pkg::GPT_IDLE;
        end else begin
            count <= next_count;
            div_cnt <= next_div_cnt;
            state <= next_state;
        end
    end

    // sticky status and the interrupt line it drives
    always_ff @(posedge mclk) begin
        if (timer_rst) begin // R13
            status <= 2'b00;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            irq <= next_irq;
        end
    end

    // read data stand for one cycle only
    always_ff @(posedge mclk) begin
        if (timer_rst) begin // R13
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_soft_self_clear: assert property (@(posedge mclk) disable iff (rst)
        soft_rst |=> !soft_rst) else $error("soft reset held too long"); // R4
    chk_soft_clears_cfg: assert property (@(posedge mclk) disable iff (rst)
        soft_rst |=> !start && !count_up && !enable) else $error("soft reset missed"); // R13
    chk_start_loads: assert property (@(posedge mclk) disable iff (timer_rst)
        start_rise && !next_soft_rst |=> count == $past(preload) && status == 2'b00)
        else $error("start did not load"); // R1
    chk_stop_holds: assert property (@(posedge mclk) disable iff (timer_rst)
        !start && !start_rise && !(reg_wr && hit(reg_addr, `GPT_OFF_COUNT)) && !next_soft_rst
        |=> $stable(count)) else $error("stopped count moved"); // R2
    chk_restart_keeps: assert property (@(posedge mclk) disable iff (timer_rst)
        complete && auto_restart && !wr_cfg |=> start && count == $past(preload))
        else $error("restart dropped start"); // R3
    chk_done_clears: assert property (@(posedge mclk) disable iff (timer_rst)
        complete && !auto_restart && !wr_cfg && !next_soft_rst
        |=> !start && state == gpt_pkg::GPT_DONE && status[0]) else $error("no done"); // R15
    chk_up_step: assert property (@(posedge mclk) disable iff (timer_rst)
        tick && !at_limit && count_up && !reg_wr |=> count == $past(count) + 32'h1)
        else $error("bad up step"); // R8
    chk_gate_off: assert property (@(posedge mclk) disable iff (timer_rst)
        !enable && !reg_wr |=> $stable(count)) else $error("gated count moved"); // R11
    // the reset cycle forces irq low whatever the next value said
    chk_irq_level: assert property (@(posedge mclk) disable iff (timer_rst) // R7
        !$past(timer_rst) |-> irq == $past(|(next_status & next_mask)))
        else $error("irq mismatch");
    chk_down_step: assert property (@(posedge mclk) disable iff (timer_rst) // R8
        tick && !at_limit && !count_up && !reg_wr |=> count == $past(count) - 32'h1)
        else $error("bad down step");
    chk_up_saturate: assert property (@(posedge mclk) disable iff (timer_rst) // R9 R10
        complete && count_up && !auto_restart && !reg_wr |=> count == 32'hffff_ffff)
        else $error("up count passed limit");
    chk_down_saturate: assert property (@(posedge mclk) disable iff (timer_rst) // R9
        complete && !count_up && !auto_restart && !reg_wr |=> count == 32'h0000_0000)
        else $error("down count passed zero");
    chk_start_clears_irq: assert property (@(posedge mclk) disable iff (timer_rst) // R1
        start_rise && !next_soft_rst |=> !irq && div_cnt == 16'h0000)
        else $error("start kept interrupt");
    chk_stop_idle: assert property (@(posedge mclk) disable iff (timer_rst) // R2
        start && wr_cfg && !reg_wdata[`GPT_CFG_START] && !reg_wdata[`GPT_CFG_SOFT_RESET]
        |=> state == gpt_pkg::GPT_IDLE && !start) else $error("stop ignored");
    chk_stop_div_hold: assert property (@(posedge mclk) disable iff (timer_rst) // R2
        state == gpt_pkg::GPT_IDLE && !start_rise |=> $stable(div_cnt))
        else $error("prescaler ran while stopped");
    chk_restart_edge: assert property (@(posedge mclk) disable iff (timer_rst) // R6
        complete && auto_restart && !wr_cfg && !next_soft_rst |=> status[1])
        else $error("no reload event");
    chk_restart_runs: assert property (@(posedge mclk) disable iff (timer_rst) // R3
        complete && auto_restart && !wr_cfg |=> state == gpt_pkg::GPT_RUN)
        else $error("restart stopped");
    chk_soft_one_pulse: assert property (@(posedge mclk) disable iff (rst) // R4
        !(wr_cfg && reg_wdata[`GPT_CFG_SOFT_RESET]) |=> !soft_rst)
        else $error("soft reset without write");
    chk_soft_clears_all: assert property (@(posedge mclk) disable iff (rst) // R13
        soft_rst |=> count == 32'h0 && preload == 32'h0 && mask == 2'b00 && status == 2'b00
        && !irq && !auto_restart) else $error("soft reset left state");
    chk_dir_reset: assert property (@(posedge mclk) disable iff (rst) // R14
        soft_rst |=> !count_up) else $error("direction not reset");
    chk_write_after_soft: assert property (@(posedge mclk) disable iff (rst) // R5
        soft_rst ##1 (!soft_rst && reg_wr && hit(reg_addr, `GPT_OFF_PRELOAD))
        |=> preload == $past(reg_wdata)) else $error("write after soft reset lost");
    chk_enable_bit: assert property (@(posedge mclk) disable iff (timer_rst) // R11
        reg_wr && hit(reg_addr, `GPT_OFF_CONTROL) |=> enable == $past(reg_wdata[0]))
        else $error("enable not written");
    chk_gate_no_tick: assert property (@(posedge mclk) disable iff (timer_rst) // R11
        !enable |-> !tick) else $error("tick while gated");
    chk_reserved_zero: assert property (@(posedge mclk) disable iff (timer_rst) // R12
        reg_rd && hit(reg_addr, `GPT_OFF_CONTROL) |=> reg_rdata[31:1] == 31'h0)
        else $error("reserved bit set");
    chk_soft_reads_zero: assert property (@(posedge mclk) disable iff (timer_rst) // R4
        reg_rd && hit(reg_addr, `GPT_OFF_CONFIG) |=> !reg_rdata[`GPT_CFG_SOFT_RESET])
        else $error("soft reset bit readable");
    chk_done_holds: assert property (@(posedge mclk) disable iff (timer_rst) // R7
        state == gpt_pkg::GPT_DONE && !reg_wr |=> state == gpt_pkg::GPT_DONE && status[0])
        else $error("done state lost");
    chk_irq_follows: assert property (@(posedge mclk) disable iff (rst) // R7
        irq == |(status & mask)) else $error("irq not status and mask");
    chk_status_w1c: assert property (@(posedge mclk) disable iff (timer_rst) // R7
        reg_wr && hit(reg_addr, `GPT_OFF_STATUS) && !complete
        |=> (status & $past(reg_wdata[1:0])) == 2'b00) else $error("status not cleared");
endmodule : gpt_timer

// >>> bench/gpt_timer_test.sv
// self-checking bench for the general purpose timer, register port and irq line
// assumes gpt_regs.svh offsets, 50 MHz mclk, synchronous active-high rst
`timescale 1ns/1ps
`include "gpt_regs.svh"
module gpt_timer_test;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic irq;
    int err_total = 0;
    int compares = 0;
    gpt_timer DUT (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
    initial begin
        forever #10 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task rchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask : rchk
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task test_done;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        for (int i = 0; i < 8; i++) rchk(8'(i * 4), 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(`GPT_OFF_CONTROL, 32'h3);
        rchk(`GPT_OFF_CONTROL, 32'h1);
        $display("test reset done");
    endtask : t_reset
    // one-shot run; 20 cycles covers preload 5 down or 5 short of all ones up at one tick a cycle
    task t_oneshot(input logic [31:0] cfg, input logic [31:0] pre, input logic [31:0] e);
        wr(`GPT_OFF_PRELOAD, pre);
        wr(`GPT_OFF_CONFIG, cfg);
        repeat (20) @(posedge mclk);
        rchk(`GPT_OFF_COUNT, e);
        rchk(`GPT_OFF_STATUS, 32'h1);
        rchk(`GPT_OFF_CONFIG, cfg & 32'h1);
        $display("test oneshot done");
    endtask : t_oneshot
    task t_irq;
        chk({31'h0, irq}, 32'h1);
        wr(`GPT_OFF_MASK, 32'h0);
        @(posedge mclk);
        #1 chk({31'h0, irq}, 32'h0);
        wr(`GPT_OFF_MASK, 32'h1);
        $display("test irq done");
    endtask : t_irq
    // the one-shot before leaves status bit0 set, which the start must wipe
    task t_auto;
        logic [31:0] c;
        wr(`GPT_OFF_PRELOAD, 32'hffff_fffd);
        wr(`GPT_OFF_CONFIG, 32'h25);
        repeat (20) @(posedge mclk);
        rchk(`GPT_OFF_STATUS, 32'h2);
        rchk(`GPT_OFF_CONFIG, 32'h25);
        wr(`GPT_OFF_CONFIG, 32'h05);
        rd(`GPT_OFF_COUNT, c);
        chk({31'h0, c >= 32'hffff_fffd}, 32'h1);
        repeat (5) @(posedge mclk);
        rchk(`GPT_OFF_COUNT, c);
        wr(`GPT_OFF_STATUS, 32'h3);
        rchk(`GPT_OFF_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        $display("test auto done");
    endtask : t_auto
    ////////////////////////////////////////////////////////////////////////////////
    task t_gated;
        wr(`GPT_OFF_CONTROL, 32'h0);
        wr(`GPT_OFF_PRELOAD, 32'h9);
        wr(`GPT_OFF_CONFIG, 32'h20);
        repeat (20) @(posedge mclk);
        rchk(`GPT_OFF_STATUS, 32'h0);
        rchk(`GPT_OFF_COUNT, 32'h9);
        wr(`GPT_OFF_CONFIG, 32'h0);
        wr(`GPT_OFF_CONTROL, 32'h1);
        $display("test gated done");
    endtask : t_gated
    task t_soft;
        wr(`GPT_OFF_PRELOAD, 32'h33);
        wr(`GPT_OFF_CONFIG, 32'h01);
        wr(`GPT_OFF_CONFIG, 32'h10);
        wr(`GPT_OFF_PRELOAD, 32'h44);
        rchk(`GPT_OFF_CONFIG, 32'h0);
        rchk(`GPT_OFF_PRELOAD, 32'h44);
        rchk(`GPT_OFF_CONTROL, 32'h0);
        rchk(`GPT_OFF_MASK, 32'h0);
        $display("test soft done");
    endtask : t_soft
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        wr(`GPT_OFF_MASK, 32'h1);
        t_oneshot(32'h20, 32'h5, 32'h0);
        t_irq();
        t_oneshot(32'h21, 32'hffff_fffa, 32'hffff_ffff);
        t_auto();
        t_gated();
        t_soft();
        test_done();
    end
    // whole run is under two hundred cycles; this is far past it
    initial begin
        #200000;
        err_total++;
        test_done();
    end
endmodule : gpt_timer_test
